// file: rtl/tcs_pkg.sv
// Shared constants for the temperature conversion scheduler
package tcs_pkg;
	localparam int TEMP_W = 11;
	localparam int RESULT_W = 12;
	localparam int CHAN_W = 2;
	localparam logic [1:0] CH_INT = 2'h0;
	localparam logic [1:0] CH_REM1 = 2'h1;
	localparam logic [1:0] CH_REM2 = 2'h2;
	localparam int NUM_TEMP = 3;
	localparam int OPEN_BIT = 11;
	localparam logic [10:0] TEMP_MAX = 11'h3ff;
	localparam logic [10:0] TEMP_MIN = 11'h400;
	localparam logic [11:0] RESULT_RST = 12'h000;
	localparam int INTEG_TIME_US = 300;
	localparam int CLK_MHZ = 10;
	localparam int INTEG_CYC = INTEG_TIME_US * CLK_MHZ;
	localparam int CONV_TIME_NS = 5000;
	localparam int CONV_CYC = CONV_TIME_NS / 100;
	localparam int SEQ_LEN = 9;
	typedef enum logic [1:0] {MODE_IDLE, MODE_CMD, MODE_AUTO} tcs_mode_e;
endpackage

// file: rtl/tcs_integrator.sv
// Background round-robin integration timer for the three temperature inputs
`timescale 1ns/10ps
module tcs_integrator #(
	parameter int INTEG_CYCLES = tcs_pkg::INTEG_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ack,
	output logic [1:0] reqChan,
	output logic reqValid
);
	logic [15:0] cnt_q, cnt_d;
	logic [1:0] chan_q, chan_d;
	logic pend_q, pend_d;

	always_comb begin
		cnt_d = cnt_q;
		chan_d = chan_q;
		pend_d = pend_q;
		// Integration keeps running while a request waits
		if (cnt_q == 16'(INTEG_CYCLES - 1)) begin
			cnt_d = 16'h0000;
			pend_d = 1'b1;
			if (!pend_q || ack) begin
				chan_d = (chan_q == tcs_pkg::CH_REM2) ? tcs_pkg::CH_INT : chan_q + 2'h1;
			end
		end else begin
			cnt_d = cnt_q + 16'h0001;
			if (ack) begin
				pend_d = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_q <= 16'h0000;
			chan_q <= tcs_pkg::CH_INT;
			pend_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			chan_q <= chan_d;
			pend_q <= pend_d;
		end
	end

	assign reqChan = (chan_q == tcs_pkg::CH_INT) ? tcs_pkg::CH_REM2 : chan_q - 2'h1;
	assign reqValid = pend_q;
endmodule

// file: rtl/tcs_result_store.sv
// Temperature result registers with offset correction and open-circuit flag
`timescale 1ns/10ps
module tcs_result_store (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire logic [1:0] wrChan,
	input wire logic [10:0] rawTemp,
	input wire logic openCircuit,
	input wire logic [10:0] offsetVal,
	output logic [11:0] resultInt,
	output logic [11:0] resultRem1,
	output logic [11:0] resultRem2
);
	logic [11:0] res_q [3];
	logic [11:0] res_d [3];

	// Saturating signed add keeps the code inside the 11-bit range
	function automatic logic [10:0] satAdd(input logic [10:0] a, input logic [10:0] b);
		logic [11:0] s;
		s = {a[10], a} + {b[10], b};
		if (s[11] != s[10]) begin
			satAdd = s[11] ? tcs_pkg::TEMP_MIN : tcs_pkg::TEMP_MAX;
		end else begin
			satAdd = s[10:0];
		end
	endfunction

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			res_d[i] = res_q[i];
		end
		if (wrEn) begin
			// Whole word at once so reads never see a mixed value
			res_d[wrChan] = {openCircuit && (wrChan != tcs_pkg::CH_INT),
				satAdd(rawTemp, offsetVal)};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				res_q[i] <= tcs_pkg::RESULT_RST;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				res_q[i] <= res_d[i];
			end
		end
	end

	assign resultInt = res_q[0];
	assign resultRem1 = res_q[1];
	assign resultRem2 = res_q[2];

	a_open_int_clear: assert property (@(posedge ref_clk) disable iff (rst)
		wrEn && wrChan == tcs_pkg::CH_INT |=> !resultInt[tcs_pkg::OPEN_BIT])
		else $error("internal result shows open flag");
	a_word_update: assert property (@(posedge ref_clk) disable iff (rst)
		!wrEn |=> $stable(resultRem1) && $stable(resultRem2) && $stable(resultInt))
		else $error("result changed without write");
	a_zero_offset: assert property (@(posedge ref_clk) disable iff (rst)
		wrEn && wrChan == tcs_pkg::CH_REM1 && offsetVal == 11'h000
		|=> resultRem1[10:0] == $past(rawTemp))
		else $error("zero offset changed code");
endmodule

// file: rtl/tcs_scheduler.sv
// Temperature conversion scheduler top: mode arbitration and shared ADC slot control
//
// Functional notes
// - Results are sign plus 10-bit twos complement, 0.25 C per LSB.
// - Code map: all ones -0.25, sign only -256, max +255.75, zero 0.
// - Temperature inputs integrate in turn continuously in the background.
// - Finished integration raises a request that starts that channel's conversion.
// - Command mode: pending temperature conversion follows the current conversion.
// - Autocycle mode: pending temperature conversion inserted between sequence slots.
// - Idle converter starts a pending temperature conversion at once.
// - Three result registers, one per channel, readable any time.
// - Command mode read-out may include remote result registers in sequence.
// - Remote result MSB set on open circuit, marking result invalid.
// - Host signed offset is added to every temperature result.
// - Converter and reference buffers off after power-up until host enables.
// - Two over-range outputs show sense amplifier above 240 mV.
// - Command mode: each read converts and returns next sequence channel.
// - Autocycle mode: channels cycled automatically, alert on range exit.
// - Alert rises on high or low limit crossing or diode fault.
`timescale 1ns/10ps
module tcs_scheduler #(
	parameter int INTEG_CYCLES = tcs_pkg::INTEG_CYC,
	parameter int CONV_CYCLES = tcs_pkg::CONV_CYC,
	parameter int SEQ_LEN = tcs_pkg::SEQ_LEN
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cmdMode,
	input wire logic autoMode,
	input wire logic [8:0] seqSelect,
	input wire logic readStrobe,
	input wire logic pwrEnable,
	input wire logic [10:0] offsetVal,
	input wire logic [10:0] adcTempCode,
	input wire logic openCircuit1,
	input wire logic openCircuit2,
	input wire logic [10:0] highLimit,
	input wire logic [10:0] lowLimit,
	input wire logic overrangeComp1,
	input wire logic overrangeComp2,
	output logic adcPowerOn,
	output logic refBufOn,
	output logic convBusy,
	output logic [3:0] convChannel,
	output logic [11:0] readData,
	output logic readValid,
	output logic [11:0] resultInt,
	output logic [11:0] resultRem1,
	output logic [11:0] resultRem2,
	output logic alert,
	output logic current_overrange_flag1,
	output logic current_overrange_flag2
);
	typedef enum logic [1:0] {S_IDLE, S_CONV, S_DONE} tcs_state_e;

	tcs_state_e state_q, state_d;
	logic [7:0] cnt_q, cnt_d;
	logic [3:0] chan_q, chan_d;
	logic isTemp_q, isTemp_d;
	logic [1:0] tchan_q, tchan_d;
	logic [3:0] seqPos_q, seqPos_d;
	logic rdPend_q, rdPend_d;
	logic [11:0] rdData_q, rdData_d;
	logic rdValid_q, rdValid_d;
	logic alert_q, alert_d;
	logic pwr_q, pwr_d;
	logic [1:0] or1Sync_q, or2Sync_q;
	logic [1:0] oc1Sync_q, oc2Sync_q;
	logic [1:0] reqChan;
	logic reqValid;
	logic tempAck;
	logic wrEn;
	logic openSel;
	logic [11:0] tempRes;

	// Next selected channel of the sequence after position p (wraps)
	function automatic logic [3:0] nextSel(input logic [8:0] sel, input logic [3:0] p);
		logic [3:0] q;
		nextSel = p;
		q = p;
		for (int i = 0; i < 9; i++) begin
			q = (q == 4'h8) ? 4'h0 : q + 4'h1;
			if (sel[q] && nextSel == p) begin
				nextSel = q;
			end
		end
	endfunction

	function automatic logic [1:0] tempOf(input logic [3:0] ch);
		tempOf = (ch == 4'h6) ? tcs_pkg::CH_REM1 :
			(ch == 4'h7) ? tcs_pkg::CH_REM2 : tcs_pkg::CH_INT;
	endfunction

	// Converter input of a temperature channel, inverse of tempOf
	function automatic logic [3:0] convIdx(input logic [1:0] t);
		convIdx = (t == tcs_pkg::CH_REM1) ? 4'h6 :
			(t == tcs_pkg::CH_REM2) ? 4'h7 : 4'h8;
	endfunction

	tcs_integrator #(
		.INTEG_CYCLES(INTEG_CYCLES)
	) uInteg (
		.ref_clk(ref_clk),
		.rst(rst),
		.ack(tempAck),
		.reqChan(reqChan),
		.reqValid(reqValid)
	);

	assign openSel = (tchan_q == tcs_pkg::CH_REM1) ? oc1Sync_q[1] :
		(tchan_q == tcs_pkg::CH_REM2) ? oc2Sync_q[1] : 1'b0;

	tcs_result_store uStore (
		.ref_clk(ref_clk),
		.rst(rst),
		.wrEn(wrEn),
		.wrChan(tchan_q),
		.rawTemp(adcTempCode),
		.openCircuit(openSel),
		.offsetVal(offsetVal),
		.resultInt(resultInt),
		.resultRem1(resultRem1),
		.resultRem2(resultRem2)
	);

	assign tempRes = (tchan_q == tcs_pkg::CH_REM1) ? resultRem1 :
		(tchan_q == tcs_pkg::CH_REM2) ? resultRem2 : resultInt;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		chan_d = chan_q;
		isTemp_d = isTemp_q;
		tchan_d = tchan_q;
		seqPos_d = seqPos_q;
		rdPend_d = rdPend_q || (cmdMode && readStrobe);
		rdData_d = rdData_q;
		rdValid_d = 1'b0;
		tempAck = 1'b0;
		wrEn = 1'b0;
		case (state_q)
			S_IDLE: begin
				if (pwr_q && reqValid) begin
					// Idle converter or slot boundary: temperature goes first
					tempAck = 1'b1;
					isTemp_d = 1'b1;
					tchan_d = reqChan;
					chan_d = convIdx(reqChan);
					cnt_d = 8'h00;
					state_d = S_CONV;
				end else if (pwr_q && ((cmdMode && rdPend_q) || autoMode) && seqSelect != 9'h000) begin
					isTemp_d = 1'b0;
					seqPos_d = nextSel(seqSelect, seqPos_q);
					chan_d = seqPos_d;
					tchan_d = tempOf(seqPos_d);
					cnt_d = 8'h00;
					state_d = S_CONV;
				end
			end
			S_CONV: begin
				if (cnt_q == 8'(CONV_CYCLES - 1)) begin
					state_d = S_DONE;
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
			end
			S_DONE: begin
				state_d = S_IDLE;
				if (isTemp_q) begin
					wrEn = 1'b1;
				end else if (cmdMode && rdPend_q) begin
					// Temperature channels 6 to 8, internal included, return the last background result
					rdData_d = (chan_q >= 4'h6) ? tempRes : {1'b0, adcTempCode};
					rdValid_d = 1'b1;
					rdPend_d = 1'b0;
				end
			end
			default: state_d = S_IDLE;
		endcase
	end

	always_comb begin
		alert_d = alert_q;
		// Sticky until both autocycle and command mode are off
		if (wrEn && ($signed(adcTempCode) > $signed(highLimit) ||
			$signed(adcTempCode) < $signed(lowLimit) || openSel)) begin
			alert_d = 1'b1;
		end else if (!autoMode && !cmdMode) begin
			alert_d = 1'b0;
		end
		pwr_d = pwrEnable;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= S_IDLE;
			cnt_q <= 8'h00;
			chan_q <= 4'h0;
			isTemp_q <= 1'b0;
			tchan_q <= tcs_pkg::CH_INT;
			seqPos_q <= 4'h8;
			rdPend_q <= 1'b0;
			rdData_q <= tcs_pkg::RESULT_RST;
			rdValid_q <= 1'b0;
			alert_q <= 1'b0;
			pwr_q <= 1'b0;
			or1Sync_q <= 2'h0;
			or2Sync_q <= 2'h0;
			oc1Sync_q <= 2'h0;
			oc2Sync_q <= 2'h0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			chan_q <= chan_d;
			isTemp_q <= isTemp_d;
			tchan_q <= tchan_d;
			seqPos_q <= seqPos_d;
			rdPend_q <= rdPend_d;
			rdData_q <= rdData_d;
			rdValid_q <= rdValid_d;
			alert_q <= alert_d;
			pwr_q <= pwr_d;
			or1Sync_q <= {or1Sync_q[0], overrangeComp1};
			or2Sync_q <= {or2Sync_q[0], overrangeComp2};
			oc1Sync_q <= {oc1Sync_q[0], openCircuit1};
			oc2Sync_q <= {oc2Sync_q[0], openCircuit2};
		end
	end

	assign adcPowerOn = pwr_q;
	assign refBufOn = pwr_q;
	assign convBusy = (state_q != S_IDLE);
	assign convChannel = chan_q;
	assign readData = rdData_q;
	assign readValid = rdValid_q;
	assign alert = alert_q;
	assign current_overrange_flag1 = or1Sync_q[1];
	assign current_overrange_flag2 = or2Sync_q[1];

	sequence sTempGrant;
		state_q == S_IDLE && pwr_q && reqValid;
	endsequence
	sequence sTempConv;
		state_q == S_CONV && isTemp_q;
	endsequence
	sequence sReadSlot;
		state_q == S_DONE && !isTemp_q && cmdMode && rdPend_q;
	endsequence

	a_idle_temp_start: assert property (@(posedge ref_clk) disable iff (rst)
		sTempGrant |=> sTempConv)
		else $error("temperature not started from idle");
	a_temp_writes: assert property (@(posedge ref_clk) disable iff (rst)
		sTempGrant |-> ##[1:300] wrEn)
		else $error("temperature conversion never written");
	a_power_gate: assert property (@(posedge ref_clk) disable iff (rst)
		!pwr_q && state_q == S_IDLE |=> state_q == S_IDLE)
		else $error("conversion while powered down");
	a_overrange_lag: assert property (@(posedge ref_clk) disable iff (rst)
		##2 current_overrange_flag1 == $past(overrangeComp1, 2))
		else $error("overrange flag mismatch");
	a_read_remote: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == S_DONE && !isTemp_q && cmdMode && rdPend_q && chan_q == 4'h6
		|=> readValid && readData == $past(resultRem1))
		else $error("remote read data wrong");
	a_alert_fault: assert property (@(posedge ref_clk) disable iff (rst)
		wrEn && openSel |=> alert)
		else $error("diode fault without alert");
	a_conv_length: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(convBusy) |-> convBusy [*2])
		else $error("conversion too short");
	a_auto_runs: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == S_IDLE && pwr_q && autoMode && seqSelect != 9'h000 |=> convBusy)
		else $error("autocycle stalled");

	// A wrong input index would hand a remote slot another channel's code
	a_temp_channel: assert property (@(posedge ref_clk) disable iff (rst)
		sTempGrant |=> convChannel == convIdx($past(reqChan)))
		else $error("temperature conversion on wrong input");
	a_temp_follows: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == S_DONE && pwrEnable && reqValid |-> ##2 sTempConv)
		else $error("pending temperature not taken next");
	a_busy_ends: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(convBusy) |-> ##[2:60] !convBusy)
		else $error("conversion never completed");
	a_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
		sReadSlot |=> readValid && !rdPend_q)
		else $error("command read not answered");
	a_read_pulse: assert property (@(posedge ref_clk) disable iff (rst)
		readValid |=> !readValid)
		else $error("read valid longer than one cycle");
	a_read_mode: assert property (@(posedge ref_clk) disable iff (rst)
		readValid |-> $past(cmdMode))
		else $error("read answered outside command mode");
	a_overrange_lag2: assert property (@(posedge ref_clk) disable iff (rst)
		##2 current_overrange_flag2 == $past(overrangeComp2, 2))
		else $error("second overrange flag mismatch");
	a_alert_clear: assert property (@(posedge ref_clk) disable iff (rst)
		!autoMode && !cmdMode && !wrEn |=> !alert)
		else $error("alert kept with both modes off");
	a_open_rem2: assert property (@(posedge ref_clk) disable iff (rst)
		wrEn && tchan_q == tcs_pkg::CH_REM2 && openSel
		|=> resultRem2[tcs_pkg::OPEN_BIT])
		else $error("remote2 open flag missing");
endmodule

// file: tb/tcs_adc_model.sv
// Behavioural converter front end returning a code for the channel in conversion
`timescale 1ns/10ps
module tcs_adc_model (
	input wire logic ref_clk,
	input wire logic [3:0] convChannel,
	input wire logic [10:0] codeInt,
	input wire logic [10:0] codeRem1,
	input wire logic [10:0] codeRem2,
	output logic [10:0] adcTempCode
);
	logic [10:0] codeQ = 11'h000;
	always @(posedge ref_clk) begin
		case (convChannel)
			4'h6: codeQ <= codeRem1;
			4'h7: codeQ <= codeRem2;
			4'h8: codeQ <= codeInt;
			// Toggles so a stale temperature is never seen by accident
			default: codeQ <= ~codeQ;
		endcase
	end
	assign adcTempCode = codeQ;
endmodule

// file: tb/temp_conversion_scheduler_tb_top.sv
// Self-checking bench for the temperature conversion scheduler
`timescale 1ns/10ps
module temp_conversion_scheduler_tb_top;
	logic ref_clk = 1'b0, rst = 1'b1, cmdMode = 1'b0, autoMode = 1'b0, readStrobe = 1'b0;
	logic pwrEnable = 1'b0, openCircuit1 = 1'b0, openCircuit2 = 1'b0;
	logic overrangeComp1 = 1'b0, overrangeComp2 = 1'b0;
	logic [8:0] seqSelect = 9'h000;
	logic [10:0] offsetVal = 11'h000, highLimit = 11'h3ff, lowLimit = 11'h400;
	logic [10:0] codeInt = 11'h123, codeRem1 = 11'h123, codeRem2 = 11'h123, adcTempCode;
	logic adcPowerOn, refBufOn, convBusy, readValid, alert, ovr1, ovr2;
	logic [3:0] convChannel;
	logic [11:0] readData, resultInt, resultRem1, resultRem2;
	int miscompares = 0, cmp_count = 0, cycles = 0;
	logic [10:0] codes [4] = '{11'h7ff, 11'h400, 11'h3ff, 11'h000};
	always #50 ref_clk = ~ref_clk;
	tcs_scheduler #(.INTEG_CYCLES(20), .CONV_CYCLES(4)) dut (.ref_clk(ref_clk), .rst(rst),
		.cmdMode(cmdMode), .autoMode(autoMode), .seqSelect(seqSelect),
		.readStrobe(readStrobe), .pwrEnable(pwrEnable), .offsetVal(offsetVal),
		.adcTempCode(adcTempCode), .openCircuit1(openCircuit1), .openCircuit2(openCircuit2),
		.highLimit(highLimit), .lowLimit(lowLimit), .overrangeComp1(overrangeComp1),
		.overrangeComp2(overrangeComp2), .adcPowerOn(adcPowerOn), .refBufOn(refBufOn),
		.convBusy(convBusy), .convChannel(convChannel), .readData(readData),
		.readValid(readValid), .resultInt(resultInt), .resultRem1(resultRem1),
		.resultRem2(resultRem2), .alert(alert), .current_overrange_flag1(ovr1),
		.current_overrange_flag2(ovr2));
	tcs_adc_model adc (.ref_clk(ref_clk), .convChannel(convChannel), .codeInt(codeInt),
		.codeRem1(codeRem1), .codeRem2(codeRem2), .adcTempCode(adcTempCode));
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		// Whole run needs under 2000 cycles
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	function automatic logic [11:0] pick(input int sel);
		return sel == 0 ? resultInt : sel == 1 ? resultRem1 : sel == 2 ? resultRem2 : readData;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Polls for an expected result, bounded by 300 cycles (five integration rounds)
	task automatic wait_res(input int sel, input logic [11:0] exp, input string msg);
		for (int i = 0; i < 300 && pick(sel) !== exp; i++) cyc(1);
		chk(pick(sel), exp, msg);
	endtask
	task automatic set_codes(input logic [10:0] c);
		@(posedge ref_clk);
		codeInt <= c;
		codeRem1 <= c;
		codeRem2 <= c;
	endtask
	task automatic t_power();
		cyc(100);
		chk({adcPowerOn, refBufOn, convBusy}, 12'h000, "off after reset");
		chk(resultInt, 12'h000, "no conversion while off");
		@(posedge ref_clk) pwrEnable <= 1'b1;
		cyc(3);
		chk({adcPowerOn, refBufOn}, 12'h003, "power on");
		chk({7'h00, convBusy, convChannel}, 12'h018, "pending internal starts at once");
		$display("test power done");
	endtask
	task automatic t_codes();
		foreach (codes[i]) begin
			set_codes(codes[i]);
			wait_res(0, {1'b0, codes[i]}, "internal code");
			wait_res(1, {1'b0, codes[i]}, "remote1 code");
			wait_res(2, {1'b0, codes[i]}, "remote2 code");
		end
		$display("test codes done");
	endtask
	task automatic t_offset();
		set_codes(11'h010);
		offsetVal <= 11'h7fc;
		wait_res(0, 12'h00c, "negative offset");
		@(posedge ref_clk) offsetVal <= 11'h004;
		wait_res(2, 12'h014, "positive offset");
		$display("test offset done");
	endtask
	task automatic t_open();
		@(posedge ref_clk) openCircuit1 <= 1'b1;
		wait_res(1, 12'h814, "open flag set");
		chk(resultRem2, 12'h014, "other remote clean");
		@(posedge ref_clk) openCircuit1 <= 1'b0;
		wait_res(1, 12'h014, "open flag cleared");
		@(posedge ref_clk) openCircuit2 <= 1'b1;
		wait_res(2, 12'h814, "remote2 open flag set");
		chk(resultRem1, 12'h014, "remote1 clean");
		@(posedge ref_clk) openCircuit2 <= 1'b0;
		wait_res(2, 12'h014, "remote2 open flag cleared");
		$display("test open done");
	endtask
	task automatic rd(input logic [11:0] exp, input string msg);
		int i;
		@(posedge ref_clk) readStrobe <= 1'b1;
		@(posedge ref_clk) readStrobe <= 1'b0;
		#1;
		for (i = 0; i < 300 && readValid !== 1'b1; i++) cyc(1);
		chk({11'h000, readValid}, 12'h001, msg);
		chk(readData, exp, msg);
	endtask
	task automatic t_cmd();
		@(posedge ref_clk);
		cmdMode <= 1'b1;
		seqSelect <= 9'h0c0;
		codeRem2 <= 11'h021;
		wait_res(2, 12'h025, "remote2 updates in command mode");
		rd(12'h014, "first in sequence remote1");
		rd(12'h025, "second in sequence remote2");
		@(posedge ref_clk) codeInt <= 11'h030;
		wait_res(0, 12'h034, "internal updates in command mode");
		@(posedge ref_clk) cmdMode <= 1'b0;
		$display("test command done");
	endtask
	task automatic t_auto();
		@(posedge ref_clk);
		autoMode <= 1'b1;
		seqSelect <= 9'h1c0;
		codeRem1 <= 11'h040;
		wait_res(1, 12'h044, "remote1 updates in autocycle");
		chk({11'h000, alert}, 12'h000, "no alert in range");
		@(posedge ref_clk) highLimit <= 11'h020;
		wait_res(2, 12'h025, "remote2 kept in autocycle");
		cyc(300);
		chk({11'h000, alert}, 12'h001, "alert over limit");
		@(posedge ref_clk) autoMode <= 1'b0;
		highLimit <= 11'h3ff;
		cyc(3);
		chk({11'h000, alert}, 12'h000, "alert cleared");
		$display("test autocycle done");
	endtask
	task automatic t_overrange();
		@(posedge ref_clk) overrangeComp1 <= 1'b1;
		cyc(3);
		chk({10'h000, ovr2, ovr1}, 12'h001, "flag1 only");
		@(posedge ref_clk) overrangeComp2 <= 1'b1;
		overrangeComp1 <= 1'b0;
		cyc(3);
		chk({10'h000, ovr2, ovr1}, 12'h002, "flag2 only");
		$display("test overrange done");
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		t_power();
		t_codes();
		t_offset();
		t_open();
		t_cmd();
		t_auto();
		t_overrange();
		stop_test();
	end
endmodule
